/* inc/emau_defines.svh */
`ifndef EMAU_DEFINES_SVH
`define EMAU_DEFINES_SVH
`define EMAU_PA_WR_ADDR 5'h01
`define EMAU_PA_WR_DHI 5'h02
`define EMAU_PA_WR_DLO 5'h03
`define EMAU_PA_WR_CTL 5'h04
`define EMAU_PA_RD_ADDR 5'h05
`define EMAU_PA_RD_CTL 5'h06
`define EMAU_PA_RD_DHI 5'h07
`define EMAU_PA_RD_DLO 5'h08
`define EMAU_PA_ERR 5'h11
`define EMAU_PA_KEY 5'h1E
`define EMAU_KEY_FIRST 16'hC418
`define EMAU_KEY_SPI 16'h0E80
`define EMAU_KEY_MAN 16'h0E81
`define EMAU_EXEC_BIT 15
`define EMAU_BUSY_BIT 8
`define EMAU_DONE_BIT 0
`define EMAU_ERR_BIT 15
`define EMAU_UNLOCK_BIT 1
`define EMAU_SHADOW_OFS 8'h40
`define EMAU_LOCK_ADDR 6'h24
`define EMAU_LOCK_MSB 25
`define EMAU_LOCK_LSB 22
`define EMAU_LOCK_NV 4'hC
`define EMAU_LOCK_ALL 4'h3
`define EMAU_XA_MARGIN 8'h84
`define EMAU_XA_COMM 8'h9E
`define EMAU_COMM_BIT 15
`define EMAU_CLK_PERIOD_NS 10
`define EMAU_NVRD_TIME_NS 2000
`define EMAU_NVRD_CYC (`EMAU_NVRD_TIME_NS / `EMAU_CLK_PERIOD_NS)
`define EMAU_NVWR_TIME_NS 10000
`define EMAU_NVWR_CYC (`EMAU_NVWR_TIME_NS / `EMAU_CLK_PERIOD_NS)
`define EMAU_MARGIN_TIME_NS 100000
`define EMAU_MARGIN_STEPS 128
`define EMAU_MARGIN_STEP_CYC (`EMAU_MARGIN_TIME_NS / (`EMAU_CLK_PERIOD_NS * `EMAU_MARGIN_STEPS))
`endif

/* inc/emau_pkg.sv */
`default_nettype none
package emau_pkg;
  typedef enum logic [2:0] {ST_COPY, ST_IDLE, ST_NVWR, ST_NVRD} emau_state_e;
  typedef enum logic [1:0] {MG_NONE, MG_PASS, MG_FAIL, MG_RUN} emau_margin_e;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [4:0] addr;
    logic [15:0] wdata;
  } emau_preq_s;
  typedef struct packed {
    logic valid;
    logic [15:0] rdata;
  } emau_prsp_s;
endpackage
`default_nettype wire

/* logic/emau_core.sv */
`include "emau_defines.svh"
`default_nettype none
module emau_core (
  // clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // primary register port
  input wire emau_pkg::emau_preq_s preq,
  output emau_pkg::emau_prsp_s prsp,
  // shadow parameters to the datapath
  input wire logic [5:0] param_sel,
  output logic [25:0] param_data,
  output logic param_ready,
  // margin sensing
  output logic margin_probe_en,
  output logic [5:0] margin_probe_addr,
  output logic margin_probe_high,
  input wire logic margin_cell_fail,
  // status
  output logic access_unlocked,
  output logic comm_mode,
  output logic ext_error,
  output logic [3:0] mem_lock
);
  import emau_pkg::*;

  function automatic logic [5:0] emau_check(input logic [25:0] d);
    logic [5:0] e;
    e = 6'h00;
    for (int i = 0; i < 26; i++) begin
      e[i % 6] = e[i % 6] ^ d[i];
    end
    return e;
  endfunction

  logic [31:0] nv_mem [64] = '{default: 32'h0000_0000};
  logic [25:0] sh_mem [64];
  logic [31:0] vol_mem [32];

  emau_state_e state_r;
  emau_margin_e mg_status_r;
  logic [7:0] wr_addr_r, rd_addr_r;
  logic [15:0] wr_dhi_r, wr_dlo_r, rd_dhi_r, rd_dlo_r;
  logic wr_busy_r, wr_done_r, rd_busy_r, rd_done_r, xee_r;
  logic key_armed_r, unlocked_r, comm_r;
  logic [9:0] cnt_r;
  logic [5:0] copy_idx_r, mg_idx_r;
  logic [6:0] mg_cnt_r;
  logic mg_thr_r, mg_hi_r;
  logic [5:0] mg_fail_addr_r;
  logic [15:0] prd_r;
  logic prv_r;
  logic reload_wr_r;

  // primary port decode
  wire p_wr = preq.wr;
  wire p_rd = preq.rd;
  wire [4:0] p_a = preq.addr;
  wire [15:0] p_d = preq.wdata;
  wire wr_exec = p_wr && p_a == `EMAU_PA_WR_CTL && p_d[`EMAU_EXEC_BIT] && !wr_busy_r;
  wire rd_exec = p_wr && p_a == `EMAU_PA_RD_CTL && p_d[`EMAU_EXEC_BIT] && !rd_busy_r;
  wire key_wr = p_wr && p_a == `EMAU_PA_KEY;
  wire key_ok = key_wr && key_armed_r && (p_d == `EMAU_KEY_SPI || p_d == `EMAU_KEY_MAN);

  // lock field lives in nonvolatile storage
  wire [3:0] lock_field = nv_mem[`EMAU_LOCK_ADDR][`EMAU_LOCK_MSB:`EMAU_LOCK_LSB];
  wire lock_all = lock_field == `EMAU_LOCK_ALL;
  wire lock_nv = lock_all || lock_field == `EMAU_LOCK_NV;

  // extended write target decode
  wire w_nv = wr_addr_r[7:6] == 2'b00;
  wire w_sh = wr_addr_r[7:6] == 2'b01;
  wire w_vol = wr_addr_r[7:5] == 3'b100;
  wire w_reject = !unlocked_r || !(w_nv || w_sh || w_vol) || lock_all || (w_nv && lock_nv);
  wire [31:0] wdata32 = {wr_dhi_r, wr_dlo_r};
  wire keep_lock = lock_nv && wr_addr_r[5:0] == `EMAU_LOCK_ADDR;
  wire [25:0] nv_merged = keep_lock ?
    {lock_field, wdata32[`EMAU_LOCK_LSB - 1:0]} : wdata32[25:0];
  wire [31:0] nv_wval = {emau_check(nv_merged), nv_merged};

  // extended read target decode
  wire r_nv = rd_addr_r[7:6] == 2'b00;
  wire r_sh = rd_addr_r[7:6] == 2'b01;
  wire r_vol = rd_addr_r[7:5] == 3'b100;
  wire r_reject = !unlocked_r || !(r_nv || r_sh || r_vol);

  // sequencer events
  wire idle = state_r == ST_IDLE;
  wire cnt_done = cnt_r == 10'h000;
  wire copy_last = copy_idx_r == 6'h3F;
  wire take_wr = idle && wr_busy_r;
  wire take_rd = idle && rd_busy_r && !wr_busy_r;
  wire nv_wr_go = take_wr && w_nv && !w_reject;
  wire nv_rd_go = take_rd && r_nv && !r_reject;
  wire nv_commit = state_r == ST_NVWR && cnt_done;
  wire wr_fin = (take_wr && !nv_wr_go) || (state_r == ST_COPY && copy_last && reload_wr_r);
  wire rd_fin = (take_rd && !nv_rd_go) || (state_r == ST_NVRD && cnt_done);
  wire wr_err = take_wr && w_reject;
  wire sh_we = take_wr && w_sh && !w_reject;
  wire vol_we = take_wr && w_vol && !w_reject;
  wire comm_we = vol_we && wr_addr_r == `EMAU_XA_COMM;
  wire mg_start = vol_we && wr_addr_r == `EMAU_XA_MARGIN && wdata32[0] && mg_status_r != MG_RUN;
  wire err_clr = p_rd && p_a == `EMAU_PA_ERR;

  // shadow write port: copy engine or extended write
  wire sh_copy = state_r == ST_COPY;
  wire [5:0] sh_idx = sh_copy ? copy_idx_r : wr_addr_r[5:0];
  wire [25:0] sh_val = sh_copy ? nv_mem[copy_idx_r][25:0] : wdata32[25:0];

  // extended read data
  wire [31:0] margin_word = {19'h00000, mg_fail_addr_r, 1'b0, mg_hi_r, mg_status_r, 3'h0};
  wire [31:0] comm_word = {16'h0000, comm_r, 15'h0000};
  wire [31:0] vol_rval = rd_addr_r == `EMAU_XA_MARGIN ? margin_word :
    rd_addr_r == `EMAU_XA_COMM ? comm_word : vol_mem[rd_addr_r[4:0]];
  wire [31:0] rd_val = r_reject ? 32'h0000_0000 : r_nv ? nv_mem[rd_addr_r[5:0]] :
    r_sh ? {6'h00, sh_mem[rd_addr_r[5:0]]} : vol_rval;

  // primary read mux
  wire [15:0] wr_ctl = {1'b0, 6'h00, wr_busy_r, 7'h00, wr_done_r};
  wire [15:0] rd_ctl = {1'b0, 6'h00, rd_busy_r, 7'h00, rd_done_r};
  wire [15:0] key_rd = {14'h0000, unlocked_r, 1'b0};
  wire [15:0] prd_mux = p_a == `EMAU_PA_WR_ADDR ? {8'h00, wr_addr_r} :
    p_a == `EMAU_PA_WR_DHI ? wr_dhi_r :
    p_a == `EMAU_PA_WR_DLO ? wr_dlo_r :
    p_a == `EMAU_PA_WR_CTL ? wr_ctl :
    p_a == `EMAU_PA_RD_ADDR ? {8'h00, rd_addr_r} :
    p_a == `EMAU_PA_RD_CTL ? rd_ctl :
    p_a == `EMAU_PA_RD_DHI ? rd_dhi_r :
    p_a == `EMAU_PA_RD_DLO ? rd_dlo_r :
    p_a == `EMAU_PA_ERR ? {xee_r, 15'h0000} :
    p_a == `EMAU_PA_KEY ? key_rd : 16'h0000;

  // staging registers, always writable
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      wr_addr_r <= 8'h00;
      wr_dhi_r <= 16'h0000;
      wr_dlo_r <= 16'h0000;
      rd_addr_r <= 8'h00;
    end else if (p_wr) begin
      if (p_a == `EMAU_PA_WR_ADDR) wr_addr_r <= p_d[7:0];
      if (p_a == `EMAU_PA_WR_DHI) wr_dhi_r <= p_d;
      if (p_a == `EMAU_PA_WR_DLO) wr_dlo_r <= p_d;
      if (p_a == `EMAU_PA_RD_ADDR) rd_addr_r <= p_d[7:0];
    end
  end

  // unlock sequence and comm mode
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      key_armed_r <= 1'b0;
      unlocked_r <= 1'b0;
      comm_r <= 1'b0;
    end else begin
      if (p_wr) key_armed_r <= key_wr && p_d == `EMAU_KEY_FIRST;
      if (key_ok) unlocked_r <= 1'b1;
      if (key_ok && p_d == `EMAU_KEY_MAN) comm_r <= 1'b1;
      else if (comm_we) comm_r <= wdata32[`EMAU_COMM_BIT];
    end
  end

  // sequencer
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      state_r <= ST_COPY;
      cnt_r <= 10'h000;
      copy_idx_r <= 6'h00;
      reload_wr_r <= 1'b0;
    end else begin
      unique case (state_r)
        ST_COPY: begin
          copy_idx_r <= copy_idx_r + 6'h01;
          if (copy_last) begin
            state_r <= ST_IDLE;
            reload_wr_r <= 1'b0;
          end
        end
        ST_IDLE: begin
          copy_idx_r <= 6'h00;
          if (nv_wr_go) begin
            state_r <= ST_NVWR;
            cnt_r <= 10'(`EMAU_NVWR_CYC - 1);
          end else if (nv_rd_go) begin
            state_r <= ST_NVRD;
            cnt_r <= 10'(`EMAU_NVRD_CYC - 1);
          end
        end
        ST_NVWR: begin
          cnt_r <= cnt_r - 10'h001;
          if (cnt_done) begin
            state_r <= ST_COPY;
            reload_wr_r <= 1'b1;
          end
        end
        ST_NVRD: begin
          cnt_r <= cnt_r - 10'h001;
          if (cnt_done) state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // write and read flags
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      wr_busy_r <= 1'b0;
      wr_done_r <= 1'b0;
      rd_busy_r <= 1'b0;
      rd_done_r <= 1'b0;
      xee_r <= 1'b0;
    end else begin
      wr_busy_r <= wr_exec || (wr_busy_r && !wr_fin);
      wr_done_r <= wr_fin || (wr_done_r && !wr_exec);
      rd_busy_r <= rd_exec || (rd_busy_r && !rd_fin);
      rd_done_r <= rd_fin || (rd_done_r && !rd_exec);
      xee_r <= wr_err || (xee_r && !err_clr);
    end
  end

  // read data capture
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      rd_dhi_r <= 16'h0000;
      rd_dlo_r <= 16'h0000;
    end else if (rd_fin) begin
      rd_dhi_r <= rd_val[31:16];
      rd_dlo_r <= rd_val[15:0];
    end
  end

  // memories
  always_ff @(posedge clk_sys) begin
    if (nv_commit) nv_mem[wr_addr_r[5:0]] <= nv_wval;
  end

  always_ff @(posedge clk_sys) begin
    if (sh_copy || sh_we) sh_mem[sh_idx] <= sh_val;
    param_data <= sh_mem[param_sel];
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      for (int i = 0; i < 32; i++) vol_mem[i] <= 32'h0000_0000;
    end else if (vol_we) begin
      vol_mem[wr_addr_r[4:0]] <= wdata32;
    end
  end

  // margin check walks both thresholds of each address, up to the first failing cell
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      mg_status_r <= MG_NONE;
      mg_idx_r <= 6'h00;
      mg_thr_r <= 1'b0;
      mg_cnt_r <= 7'h00;
      mg_hi_r <= 1'b0;
      mg_fail_addr_r <= 6'h00;
    end else if (mg_start) begin
      mg_status_r <= MG_RUN;
      mg_idx_r <= 6'h00;
      mg_thr_r <= 1'b0;
      mg_cnt_r <= 7'(`EMAU_MARGIN_STEP_CYC - 1);
    end else if (mg_status_r == MG_RUN) begin
      mg_cnt_r <= mg_cnt_r - 7'h01;
      if (mg_cnt_r == 7'h00) begin
        mg_cnt_r <= 7'(`EMAU_MARGIN_STEP_CYC - 1);
        mg_thr_r <= !mg_thr_r;
        if (mg_thr_r) mg_idx_r <= mg_idx_r + 6'h01;
        if (margin_cell_fail) begin
          mg_status_r <= MG_FAIL;
          mg_hi_r <= mg_thr_r;
          mg_fail_addr_r <= mg_idx_r;
        end else if (mg_thr_r && mg_idx_r == 6'h3F) begin
          mg_status_r <= MG_PASS;
        end
      end
    end
  end

  // primary read response
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      prd_r <= 16'h0000;
      prv_r <= 1'b0;
    end else begin
      prv_r <= p_rd;
      if (p_rd) prd_r <= prd_mux;
    end
  end

  assign prsp = '{valid: prv_r, rdata: prd_r};
  assign param_ready = !sh_copy;
  assign margin_probe_en = mg_status_r == MG_RUN;
  assign margin_probe_addr = mg_idx_r;
  assign margin_probe_high = mg_thr_r;
  assign access_unlocked = unlocked_r;
  assign comm_mode = comm_r;
  assign ext_error = xee_r;
  assign mem_lock = lock_field;

  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  a_unlock_pair: assert property ($rose(unlocked_r) |-> $past(key_armed_r) && $past(key_wr))
    else $error("unlock without key pair");
  a_unlock_read: assert property (p_rd && p_a == `EMAU_PA_KEY |=> prsp.rdata[1] == $past(unlocked_r))
    else $error("unlock bit wrong");
  a_stage_readback: assert property (p_wr && p_a == `EMAU_PA_WR_DHI ##1 p_rd && p_a == `EMAU_PA_WR_DHI && !p_wr
    |=> prsp.rdata == $past(p_d, 2))
    else $error("staging readback wrong");
  a_comm_off: assert property (comm_we && !wdata32[`EMAU_COMM_BIT] && !key_ok |=> !comm_mode)
    else $error("comm mode not ended");
  a_nv_lock_rej: assert property (take_wr && w_nv && lock_nv |=> ext_error && wr_done_r && state_r == ST_IDLE)
    else $error("locked nonvolatile write not refused");
  a_all_lock_rej: assert property (take_wr && lock_all |=> ext_error && !wr_busy_r)
    else $error("locked write not refused");
  a_lock_sticky: assert property (lock_nv |=> lock_nv && $stable(lock_field))
    else $error("lock field changed");
  a_write_flags: assert property (wr_exec |=> wr_busy_r && !wr_done_r)
    else $error("write flags wrong at start");
  a_write_end: assert property ($fell(wr_busy_r) |-> wr_done_r)
    else $error("write ended without done");
  a_nvrd_time: assert property (nv_rd_go |=> rd_busy_r [*3] ##[1:198] rd_done_r && !rd_busy_r)
    else $error("nonvolatile read too slow");
  a_fast_read: assert property (take_rd && !nv_rd_go |=> rd_done_r && !rd_busy_r)
    else $error("shadow read not immediate");
  a_margin_run: assert property (mg_start |=> mg_status_r == MG_RUN && margin_probe_en)
    else $error("margin not running");
  a_exec_ignore: assert property (wr_busy_r && !wr_fin && p_wr && p_a == `EMAU_PA_WR_CTL |=> !wr_done_r)
    else $error("execute accepted while busy");

  c_unlock: cover property ($rose(unlocked_r));
  c_nv_write: cover property (nv_commit ##[1:80] $rose(wr_done_r));
  c_margin_fail: cover property (mg_status_r == MG_RUN ##1 mg_status_r == MG_FAIL);
endmodule
`default_nettype wire

/* dv/emau_host.sv */
`default_nettype none
module emau_host (
  // primary register port
  input wire logic clk_sys,
  output emau_pkg::emau_preq_s preq,
  input wire emau_pkg::emau_prsp_s prsp
);
  timeunit 1ns;
  timeprecision 1ps;
  import emau_pkg::*;
  initial preq = '0;
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(negedge clk_sys);
    preq <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge clk_sys);
    preq <= '0;
  endtask
  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    @(negedge clk_sys);
    preq <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
    @(negedge clk_sys);
    preq <= '0;
    @(negedge clk_sys);
    d = prsp.rdata;
  endtask
  task automatic unlock(input logic [15:0] k);
    wr(5'h1E, 16'hC418);
    wr(5'h1E, k);
  endtask
  task automatic xwr(input logic [7:0] a, input logic [31:0] d, output logic [15:0] s0);
    logic [15:0] s;
    wr(5'h01, {8'h00, a});
    wr(5'h02, d[31:16]);
    wr(5'h03, d[15:0]);
    wr(5'h04, 16'h8000);
    rd(5'h04, s0);
    s = s0;
    for (int i = 0; i < 1000 && !s[0]; i++) rd(5'h04, s);
  endtask
  task automatic xrd(input logic [7:0] a, output logic [31:0] d, output int c, output logic [15:0] s0);
    logic [15:0] s;
    time t;
    wr(5'h05, {8'h00, a});
    wr(5'h06, 16'h8000);
    t = $time;
    rd(5'h06, s0);
    s = s0;
    for (int i = 0; i < 1000 && !s[0]; i++) rd(5'h06, s);
    c = int'(($time - t) / 10);
    rd(5'h07, d[31:16]);
    rd(5'h08, d[15:0]);
  endtask
endmodule
`default_nettype wire

/* dv/testbench.sv */
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import emau_pkg::*;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  emau_preq_s preq;
  emau_prsp_s prsp;
  logic [5:0] param_sel = 6'h00;
  logic [25:0] param_data;
  logic param_ready, margin_probe_en, margin_probe_high;
  logic margin_cell_fail = 1'b0;
  logic [5:0] margin_probe_addr;
  logic access_unlocked, comm_mode, ext_error;
  logic [3:0] mem_lock;
  int error_cnt = 0;
  int cmp_count = 0;
  logic [31:0] mdl [256] = '{default: 32'h0};
  logic unl = 1'b0;
  logic [3:0] lck = 4'h0;
  logic fail_en = 1'b0;
  logic [5:0] fa = 6'h00;
  logic fh = 1'b0;
  emau_core u_emau_core (.clk_sys, .resetn, .preq, .prsp, .param_sel, .param_data, .param_ready,
    .margin_probe_en, .margin_probe_addr, .margin_probe_high, .margin_cell_fail,
    .access_unlocked, .comm_mode, .ext_error, .mem_lock);
  emau_host host (.clk_sys, .preq, .prsp);
  always #5 clk_sys = ~clk_sys;
  always @(negedge clk_sys) begin
    param_sel <= 6'($urandom);
    margin_cell_fail <= fail_en && margin_probe_addr === fa && margin_probe_high === fh;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic stop_test();
    $display("comparisons %0d errors %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // shadow follows nonvolatile without check bits
  function automatic void reload();
    for (int i = 0; i < 64; i++) mdl[i + 64] = {6'h00, mdl[i][25:0]};
  endfunction
  task automatic rst();
    @(negedge clk_sys);
    resetn <= 1'b0;
    repeat (5) @(negedge clk_sys);
    resetn <= 1'b1;
    unl = 1'b0;
    for (int i = 128; i < 160; i++) mdl[i] = 32'h0;
    reload();
    repeat (3) @(negedge clk_sys);
    chk(param_ready, 1'b0);
    repeat (70) @(negedge clk_sys);
    chk(param_ready, 1'b1);
    chk(comm_mode, 1'b0);
  endtask
  task automatic wx(input logic [7:0] a, input logic [31:0] d);
    logic [15:0] s;
    logic er;
    er = !unl || a >= 8'hA0 || lck == 4'h3 || (lck == 4'hC && a < 8'h40);
    host.xwr(a, d, s);
    if (!er && a < 8'h40) chk(s[8], 1'b1);
    if (!er) begin
      mdl[a] = (a >= 8'h40 && a < 8'h80) ? {6'h00, d[25:0]} : d;
      if (a == 8'h24 && lck == 4'h0) lck = d[25:22];
      if (a < 8'h40) reload();
    end
    host.rd(5'h04, s);
    chk(s[8:0], 9'h001);
    host.rd(5'h11, s);
    chk(s[15], er);
  endtask
  task automatic rx(input logic [7:0] a, output logic [31:0] d);
    logic [15:0] s;
    logic [31:0] e;
    int c;
    host.xrd(a, d, c, s);
    e = unl ? mdl[a] : 32'h0;
    if (a < 8'h40) begin
      e[31:26] = 6'h00;
      d[31:26] = 6'h00;
      if (unl) chk(s[8], 1'b1);
    end
    chk(d, e);
    chk(c <= 212, 1'b1);
  endtask
  task automatic margin(input logic [1:0] st);
    logic [31:0] d;
    logic [15:0] s;
    int c;
    wx(8'h84, 32'h1);
    host.xrd(8'h84, d, c, s);
    chk(d[4:3], 2'h3);
    for (int i = 0; i < 200 && d[4:3] == 2'h3; i++) begin
      repeat (100) @(negedge clk_sys);
      host.xrd(8'h84, d, c, s);
    end
    chk(d[4:3], st);
    if (st == 2'h2) chk({d[12:7], d[5]}, {fa, fh});
    chk(ext_error, 1'b0);
  endtask
  initial begin
    logic [15:0] s;
    logic [31:0] d;
    logic [7:0] a;
    void'($urandom(50));
    rst();
    host.rd(5'h1E, s);
    chk(s[1], 1'b0);
    wx(8'h45, 32'h0000_1234);
    rx(8'h45, d);
    host.wr(5'h1E, 16'hC418);
    host.wr(5'h01, 16'h0000);
    host.wr(5'h1E, 16'h0E80);
    host.rd(5'h1E, s);
    chk(s[1], 1'b0);
    host.unlock(16'h0E80);
    unl = 1'b1;
    host.rd(5'h1E, s);
    chk(s[1], 1'b1);
    repeat (4) begin
      a = 8'h40 | 8'($urandom_range(31));
      wx(a, $urandom);
      rx(a, d);
    end
    a = 8'h10 | 8'($urandom_range(15));
    wx(a, $urandom);
    rx(a, d);
    rx(a + 8'h40, d);
    wx(8'h90, 32'hA5A5_5A5A);
    rx(8'h90, d);
    rst();
    host.unlock(16'h0E81);
    unl = 1'b1;
    chk(comm_mode, 1'b1);
    rx(8'h90, d);
    wx(8'h9E, 32'h0);
    chk(comm_mode, 1'b0);
    fa = 6'($urandom_range(63));
    fh = 1'($urandom);
    fail_en = 1'b1;
    margin(2'h2);
    fail_en = 1'b0;
    margin(2'h1);
    wx(8'h24, 32'h0300_0000);
    chk(mem_lock, 4'hC);
    wx(8'h11, 32'h1);
    wx(8'h51, 32'h2);
    wx(8'h24, 32'h00C0_0000);
    chk(mem_lock, 4'hC);
    rx(8'h11, d);
    stop_test();
  end
  initial begin
    #1000000;
    error_cnt++;
    stop_test();
  end
endmodule
`default_nettype wire
